// >>> hw/bsp_regs.svh
`ifndef BSP_REGS_SVH
`define BSP_REGS_SVH
// ==========================================================
// Register offsets and fields.
`define BSP_CTRL_OFS 12'h000
`define BSP_PAGE_OFS 12'h004
`define BSP_PC_OFS 12'h008
`define BSP_STAT_OFS 12'h00c
`define BSP_CTRL_RUN_BIT 0
`define BSP_STAT_IDLE_BIT 0
`define BSP_STAT_ZERO_BIT 1
`define BSP_STAT_BORROW_BIT 2
// ==========================================================
// Reset values.
`define BSP_PC_RST 16'h0000
`define BSP_PAGE_RST 16'h0000
// ==========================================================
// Instruction encoding.
`define BSP_FMT_A 2'h0
`define BSP_FMT_C 2'h1
`define BSP_FMT_B1 2'h2
`define BSP_FMT_B2 2'h3
`define BSP_OP_HALF_LOAD 3'h0
`define BSP_OP_LOW_LOAD 3'h1
`define BSP_OP_HIGH_LOAD 3'h2
`define BSP_OP_HALF_STORE 3'h3
`define BSP_OP_LOW_STORE 3'h4
`define BSP_OP_HIGH_STORE 3'h5
`define BSP_OP_LOW_LIT 3'h6
`define BSP_OP_HIGH_LIT 3'h7
`define BSP_OP_NOP 3'h0
`define BSP_OP_CMPI 3'h1
`define BSP_OP_ANDI 3'h2
`define BSP_OP_BRANCH 3'h3
`define BSP_OP_CALL 3'h4
`define BSP_OP_SUM_LIT 3'h5
`define BSP_OP_JUMP_REG 3'h6
`define BSP_OP_SUB_EXIT 3'h7
`define BSP_OP_RESUME 3'h0
`define BSP_OP_BREAK 3'h1
// ==========================================================
// Program counter step.
`define BSP_PC_STEP 16'h0002
`endif

// >>> hw/bsp_pkg.sv
package bsp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_IWAIT, ST_DECODE, ST_EXEC, ST_LWAIT, ST_LCAP
    } bsp_state_type;
    typedef logic [15:0] bsp_word_type;
endpackage

// >>> hw/bsp_fmt_ab_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_regs.svh"
module bsp_fmt_ab_exec import bsp_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction memory.
    output logic [15:0] instrAddrBus,
    input wire logic [15:0] instrDataIn,
    // Data memory.
    output logic [15:0] dataAddrBus,
    output logic [15:0] dataWriteBus,
    output logic dataWriteEn,
    output logic dataReadEn,
    output logic dataHalfword,
    input wire logic [15:0] dataReadBus,
    // Condition inputs and events.
    input wire logic externalCond0,
    input wire logic externalCond1,
    input wire logic externalCond2,
    input wire logic externalCond3,
    output logic resumeStrobe
);
    // ==========================================================
    // State.
    bsp_state_type stateReg;
    bsp_word_type pcReg;
    bsp_word_type irReg;
    bsp_word_type eaReg;
    bsp_word_type pageReg;
    bsp_word_type tgtReg;
    bsp_word_type linkReg;
    logic [7:0][15:0] gprReg;
    logic zeroReg;
    logic borrowReg;
    logic slotReg;
    logic runReg;

    // ==========================================================
    // Field decode.
    logic [1:0] fmt;
    logic [2:0] op;
    logic [2:0] sel;
    logic [7:0] imm;
    logic [3:0] ext;
    logic isA;
    logic isB1;
    logic isB2;
    logic isLoad;
    logic isStore;
    logic condOk;
    logic inExec;
    logic doBreak;
    logic taken;
    logic quietOp;
    logic [8:0] cmpDiff;
    assign fmt = irReg[15:14];
    assign op = irReg[13:11];
    assign sel = irReg[10:8];
    assign imm = irReg[7:0];
    assign ext = {externalCond3, externalCond2, externalCond1, externalCond0};
    assign isA = fmt == `BSP_FMT_A;
    assign isB1 = fmt == `BSP_FMT_B1;
    assign isB2 = fmt == `BSP_FMT_B2;
    assign isLoad = isA && op <= `BSP_OP_HIGH_LOAD;
    assign isStore = isA && op >= `BSP_OP_HALF_STORE && op <= `BSP_OP_HIGH_STORE;
    assign inExec = stateReg == ST_EXEC;
    assign doBreak = inExec && isB2 && op == `BSP_OP_BREAK;
    assign cmpDiff = {1'b0, gprReg[sel][7:0]} - {1'b0, imm};
    assign quietOp = fmt == `BSP_FMT_C || (isB1 && op == `BSP_OP_NOP) || isB2;

    function automatic logic condHolds(input logic [2:0] c, input logic lastIsExt,
                                       input logic z, input logic b, input logic [3:0] e);
        case (c)
            3'h0: condHolds = z;
            3'h1: condHolds = !z;
            3'h2: condHolds = !b;
            3'h3: condHolds = b;
            3'h4: condHolds = e[0];
            3'h5: condHolds = e[1];
            3'h6: condHolds = e[2];
            default: condHolds = lastIsExt ? e[3] : 1'b1;
        endcase
    endfunction

    function automatic bsp_word_type eaCalc(input bsp_word_type instr,
                                            input bsp_word_type page);
        logic half;
        half = instr[13:11] == `BSP_OP_HALF_LOAD || instr[13:11] == `BSP_OP_HALF_STORE;
        if (half) begin
            eaCalc = page + {7'h00, instr[7:0], 1'b0};
        end else begin
            eaCalc = page + {8'h00, instr[7:0]};
        end
    endfunction

    assign condOk = condHolds(sel, op == `BSP_OP_BRANCH || op == `BSP_OP_CALL,
                              zeroReg, borrowReg, ext);
    assign taken = inExec && isB1 && condOk && (op == `BSP_OP_BRANCH ||
                   op == `BSP_OP_CALL || op == `BSP_OP_JUMP_REG || op == `BSP_OP_SUB_EXIT);

    // ==========================================================
    // APB slave.
    logic apbWr;
    logic apbHit;
    logic [31:0] rdMux;
    assign apbWr = psel && penable && pready && pwrite;

    always_comb begin
        rdMux = 32'h0000_0000;
        apbHit = 1'b1;
        case (paddr)
            `BSP_CTRL_OFS: rdMux[`BSP_CTRL_RUN_BIT] = runReg;
            `BSP_PAGE_OFS: rdMux[15:0] = pageReg;
            `BSP_PC_OFS: rdMux[15:0] = pcReg;
            `BSP_STAT_OFS: begin
                rdMux[`BSP_STAT_IDLE_BIT] = stateReg == ST_IDLE;
                rdMux[`BSP_STAT_ZERO_BIT] = zeroReg;
                rdMux[`BSP_STAT_BORROW_BIT] = borrowReg;
            end
            default: apbHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !apbHit;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            runReg <= 1'b0;
            pageReg <= `BSP_PAGE_RST;
        end else begin
            if (doBreak) begin
                runReg <= 1'b0;
            end
            if (apbWr && paddr == `BSP_CTRL_OFS) begin
                runReg <= pwdata[`BSP_CTRL_RUN_BIT];
            end
            if (apbWr && paddr == `BSP_PAGE_OFS) begin
                pageReg <= pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Sequencer.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= ST_IDLE;
        end else begin
            case (stateReg)
                ST_IDLE: stateReg <= runReg ? ST_FETCH : ST_IDLE;
                ST_FETCH: stateReg <= ST_IWAIT;
                ST_IWAIT: stateReg <= ST_DECODE;
                ST_DECODE: stateReg <= ST_EXEC;
                ST_EXEC: begin
                    if (isLoad) begin
                        stateReg <= ST_LWAIT;
                    end else begin
                        stateReg <= (runReg && !doBreak) ? ST_FETCH : ST_IDLE;
                    end
                end
                ST_LWAIT: stateReg <= ST_LCAP;
                ST_LCAP: stateReg <= runReg ? ST_FETCH : ST_IDLE;
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Fetch, decode and program flow.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pcReg <= `BSP_PC_RST;
            instrAddrBus <= `BSP_PC_RST;
            irReg <= 16'h0000;
            eaReg <= 16'h0000;
            tgtReg <= 16'h0000;
            linkReg <= 16'h0000;
            slotReg <= 1'b0;
        end else begin
            if (stateReg == ST_IDLE && apbWr && paddr == `BSP_PC_OFS) begin
                pcReg <= pwdata[15:0];
            end
            if (stateReg == ST_FETCH) begin
                instrAddrBus <= pcReg;
                pcReg <= pcReg + `BSP_PC_STEP;
            end
            if (stateReg == ST_DECODE) begin
                irReg <= instrDataIn;
                eaReg <= eaCalc(instrDataIn, pageReg);
            end
            if (inExec) begin
                slotReg <= taken;
                if (slotReg) begin
                    pcReg <= tgtReg;
                end
                if (taken) begin
                    case (op)
                        `BSP_OP_JUMP_REG: tgtReg <= gprReg[sel];
                        `BSP_OP_SUB_EXIT: tgtReg <= linkReg;
                        default: tgtReg <= pcReg + {{8{imm[7]}}, imm};
                    endcase
                    if (op == `BSP_OP_CALL) begin
                        linkReg <= pcReg + `BSP_PC_STEP;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Data memory port.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dataAddrBus <= 16'h0000;
            dataWriteBus <= 16'h0000;
            dataWriteEn <= 1'b0;
            dataReadEn <= 1'b0;
            dataHalfword <= 1'b0;
        end else begin
            dataWriteEn <= inExec && isStore;
            dataReadEn <= inExec && isLoad;
            if (inExec && (isLoad || isStore)) begin
                dataAddrBus <= eaReg;
                dataHalfword <= op == `BSP_OP_HALF_LOAD || op == `BSP_OP_HALF_STORE;
                case (op)
                    `BSP_OP_HALF_STORE: dataWriteBus <= gprReg[sel];
                    `BSP_OP_HIGH_STORE: dataWriteBus <= {8'h00, gprReg[sel][15:8]};
                    default: dataWriteBus <= {8'h00, gprReg[sel][7:0]};
                endcase
            end
        end
    end

    // ==========================================================
    // Register file.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gprReg <= '0;
        end else begin
            if (inExec && isA && op == `BSP_OP_LOW_LIT) begin
                gprReg[sel][7:0] <= imm;
            end
            if (inExec && isA && op == `BSP_OP_HIGH_LIT) begin
                gprReg[sel][15:8] <= imm;
            end
            if (inExec && isB1 && op == `BSP_OP_SUM_LIT) begin
                gprReg[sel] <= gprReg[sel] + {8'h00, imm};
            end
            if (stateReg == ST_LCAP) begin
                case (op)
                    `BSP_OP_HALF_LOAD: gprReg[sel] <= dataReadBus;
                    `BSP_OP_LOW_LOAD: gprReg[sel][7:0] <= dataReadBus[7:0];
                    default: gprReg[sel][15:8] <= dataReadBus[7:0];
                endcase
            end
        end
    end

    // ==========================================================
    // Flags and events.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zeroReg <= 1'b0;
            borrowReg <= 1'b0;
            resumeStrobe <= 1'b0;
        end else begin
            resumeStrobe <= inExec && isB2 && op == `BSP_OP_RESUME;
            if (inExec && isB1 && op == `BSP_OP_CMPI) begin
                zeroReg <= cmpDiff[7:0] == 8'h00;
                borrowReg <= cmpDiff[8];
            end
            if (inExec && isB1 && op == `BSP_OP_ANDI) begin
                zeroReg <= (gprReg[sel][7:0] & imm) == 8'h00;
                borrowReg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_loadCap;
        stateReg == ST_LCAP && isA && op == `BSP_OP_HALF_LOAD;
    endsequence
    sequence s_branchTaken;
        inExec && isB1 && op == `BSP_OP_BRANCH && condOk;
    endsequence

    a_fetch_pc_step: assert property (stateReg == ST_FETCH |=>
        instrAddrBus == $past(pcReg) && pcReg == $past(pcReg) + 16'h0002)
        else $error("fetch did not drive and step the counter");
    a_half_addr_scale: assert property (stateReg == ST_DECODE &&
        instrDataIn[15:14] == `BSP_FMT_A && instrDataIn[13:11] == `BSP_OP_HALF_LOAD |=>
        eaReg == $past(pageReg) + {7'h00, $past(instrDataIn[7:0]), 1'b0})
        else $error("halfword address not scaled");
    a_byte_addr_plain: assert property (stateReg == ST_DECODE &&
        instrDataIn[15:14] == `BSP_FMT_A && instrDataIn[13:11] == `BSP_OP_LOW_STORE |=>
        eaReg == $past(pageReg) + {8'h00, $past(instrDataIn[7:0])})
        else $error("byte address wrong");
    a_store_drive: assert property (inExec && isStore |=>
        dataWriteEn && dataAddrBus == $past(eaReg) ##1 !dataWriteEn)
        else $error("store not driven for one cycle");
    a_load_capture: assert property (s_loadCap |=>
        gprReg[$past(sel)] == $past(dataReadBus))
        else $error("load data not captured");
    a_literal_low: assert property (inExec && isA && op == `BSP_OP_LOW_LIT |=>
        gprReg[$past(sel)][7:0] == $past(imm) && !dataWriteEn && !dataReadEn)
        else $error("low literal not written");
    a_compare_flags: assert property (inExec && isB1 && op == `BSP_OP_CMPI |=>
        gprReg == $past(gprReg) && zeroReg == ($past(cmpDiff[7:0]) == 8'h00))
        else $error("compare flags wrong");
    a_branch_slot: assert property (s_branchTaken |=>
        slotReg && tgtReg == $past(pcReg) + {{8{$past(imm[7])}}, $past(imm)} &&
        stateReg == ST_FETCH ##2 instrAddrBus == $past(pcReg, 2))
        else $error("branch delay slot wrong");
    a_jump_target: assert property (taken && op == `BSP_OP_JUMP_REG |=>
        tgtReg == $past(gprReg[sel]) && slotReg)
        else $error("register jump target wrong");
    a_call_link: assert property (taken && op == `BSP_OP_CALL |=>
        linkReg == $past(pcReg) + 16'h0002)
        else $error("call link wrong");
    a_nop_quiet: assert property (inExec && quietOp |=>
        gprReg == $past(gprReg) && zeroReg == $past(zeroReg) && !dataWriteEn)
        else $error("no-op changed state");
endmodule
`default_nettype wire

// >>> testbench/bsp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Instruction and data memory on the far side of the processor.
module bsp_mem_model import bsp_pkg::*; (
    // Clock.
    input wire logic clk_sys,
    // Instruction side.
    input wire logic [15:0] instrAddrBus,
    output logic [15:0] instrDataIn,
    // Data side.
    input wire logic [15:0] dataAddrBus,
    input wire logic [15:0] dataWriteBus,
    input wire logic dataWriteEn,
    input wire logic dataReadEn,
    input wire logic dataHalfword,
    output logic [15:0] dataReadBus
);
    logic [15:0] progMem [0:255];
    logic [7:0] dataMem [0:65535];
    logic [15:0] addrNext;
    assign addrNext = dataAddrBus + 16'h0001;
    // Both memories answer one edge after the request, as synchronous RAM does.
    always @(posedge clk_sys) begin
        instrDataIn <= progMem[instrAddrBus[8:1]];
        if (dataWriteEn === 1'b1) begin
            dataMem[dataAddrBus] <= dataWriteBus[7:0];
            if (dataHalfword === 1'b1) begin
                dataMem[addrNext] <= dataWriteBus[15:8];
            end
        end
        // Outside a read the bus flips, so stale data never passes for fresh.
        if (dataReadEn === 1'b1) begin
            dataReadBus <= {dataHalfword ? dataMem[addrNext] : ~dataMem[dataAddrBus],
                dataMem[dataAddrBus]};
        end else begin
            dataReadBus <= ~dataReadBus;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsp_regs.svh"
`define CHK(got, exp) begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
        nMismatch++; \
        $display("unexpected at %0t ns: got %h, expected %h", $time, (got), (exp)); \
    end \
end
// ==========================================================
// Self-checking bench: programs run from the memory model.
module tb_top import bsp_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] instrAddrBus;
    logic [15:0] instrDataIn;
    logic [15:0] dataAddrBus;
    logic [15:0] dataWriteBus;
    logic dataWriteEn;
    logic dataReadEn;
    logic dataHalfword;
    logic [15:0] dataReadBus;
    logic [3:0] extCond = 4'h0;
    logic resumeStrobe;
    int nMismatch = 0;
    int checksDone = 0;
    int resumeCount = 0;
    logic [31:0] rdv;
    logic erv;
    logic [15:0] progPtr;
    logic [7:0] imms [0:2] = '{8'h40, 8'hcc, 8'h01};
    logic [31:0] stats [0:2] = '{32'h5, 32'h3, 32'h1};
    logic [3:0] ext;
    logic tk;

    always #4 clk_sys = ~clk_sys;

    bsp_fmt_ab_exec uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instrAddrBus(instrAddrBus), .instrDataIn(instrDataIn),
        .dataAddrBus(dataAddrBus), .dataWriteBus(dataWriteBus), .dataWriteEn(dataWriteEn),
        .dataReadEn(dataReadEn), .dataHalfword(dataHalfword), .dataReadBus(dataReadBus),
        .externalCond0(extCond[0]), .externalCond1(extCond[1]), .externalCond2(extCond[2]),
        .externalCond3(extCond[3]), .resumeStrobe(resumeStrobe));

    bsp_mem_model mem (.clk_sys(clk_sys), .instrAddrBus(instrAddrBus),
        .instrDataIn(instrDataIn), .dataAddrBus(dataAddrBus), .dataWriteBus(dataWriteBus),
        .dataWriteEn(dataWriteEn), .dataReadEn(dataReadEn), .dataHalfword(dataHalfword),
        .dataReadBus(dataReadBus));

    always @(posedge clk_sys) begin
        if (resumeStrobe === 1'b1) begin
            resumeCount++;
        end
    end

    function automatic logic [15:0] ia(input logic [2:0] o, input logic [2:0] r,
        input logic [7:0] i);
        return {`BSP_FMT_A, o, r, i};
    endfunction
    function automatic logic [15:0] ib(input logic [2:0] o, input logic [2:0] r,
        input logic [7:0] i);
        return {`BSP_FMT_B1, o, r, i};
    endfunction
    localparam logic [15:0] BRK = {`BSP_FMT_B2, `BSP_OP_BREAK, 11'h000};

    task automatic giveVerdict();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) nMismatch++;
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        `CHK(rdv, exp)
        `CHK(erv, err)
    endtask

    task automatic emit(input logic [15:0] w);
        mem.progMem[progPtr[8:1]] = w;
        progPtr += 16'h0002;
    endtask

    task automatic runProg(input logic [15:0] start);
        int n;
        n = 0;
        apb(1'b1, `BSP_PC_OFS, {16'h0, start});
        apb(1'b1, `BSP_CTRL_OFS, 32'h1);
        do begin
            apb(1'b0, `BSP_STAT_OFS, 32'h0);
            n++;
        end while (rdv[0] !== 1'b1 && n < 200);
        if (n >= 200) nMismatch++;
    endtask

    task automatic clearMarks();
        for (int k = 0; k < 4; k++) begin
            mem.dataMem[16'h0100 + k] = 8'h00;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        nMismatch++;
        giveVerdict();
    end

    initial begin
        for (int k = 0; k < 256; k++) begin
            mem.progMem[k] = BRK;
        end
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(`BSP_CTRL_OFS, 32'h0, 1'b0);
        rdChk(`BSP_PAGE_OFS, 32'h0, 1'b0);
        rdChk(`BSP_PC_OFS, 32'h0, 1'b0);
        rdChk(`BSP_STAT_OFS, 32'h1, 1'b0);
        rdChk(12'h010, 32'h0, 1'b1);
        apb(1'b1, `BSP_STAT_OFS, 32'h6);
        rdChk(`BSP_STAT_OFS, 32'h1, 1'b0);
        // Operands stay within 0x1fe bytes above the base; halfword offsets are scaled by two.
        apb(1'b1, `BSP_PAGE_OFS, 32'h0100);
        rdChk(`BSP_PAGE_OFS, 32'h0100, 1'b0);
        mem.dataMem[16'h0280] = 8'hcd;
        mem.dataMem[16'h0281] = 8'hab;
        mem.dataMem[16'h0105] = 8'h5a;
        mem.dataMem[16'h0106] = 8'ha5;
        progPtr = 16'h0000;
        emit(ia(6, 1, 8'h34));
        emit(ia(7, 1, 8'h12));
        emit(ib(`BSP_OP_NOP, 1, 8'hff));
        emit(16'h4000);
        emit(16'hf800);
        emit({`BSP_FMT_B2, `BSP_OP_RESUME, 11'h000});
        emit(ia(3, 1, 8'h80));
        emit(ia(4, 1, 8'hff));
        emit(ia(5, 1, 8'h10));
        emit(ia(0, 2, 8'hc0));
        emit(ia(1, 3, 8'h05));
        emit(ia(2, 3, 8'h06));
        emit(ia(3, 2, 8'h81));
        emit(ia(3, 3, 8'h82));
        emit(BRK);
        runProg(16'h0000);
        `CHK({mem.dataMem[16'h0201], mem.dataMem[16'h0200]}, 16'h1234)
        `CHK(mem.dataMem[16'h01ff], 8'h34)
        `CHK(mem.dataMem[16'h0110], 8'h12)
        `CHK({mem.dataMem[16'h0203], mem.dataMem[16'h0202]}, 16'habcd)
        `CHK({mem.dataMem[16'h0205], mem.dataMem[16'h0204]}, 16'ha55a)
        `CHK(resumeCount, 1)
        rdChk(`BSP_STAT_OFS, 32'h1, 1'b0);
        rdChk(`BSP_PC_OFS, 32'h1e, 1'b0);
        progPtr = 16'h0060;
        emit(ib(`BSP_OP_SUM_LIT, 1, 8'hff));
        emit(ia(3, 1, 8'h83));
        emit(ib(`BSP_OP_CMPI, 1, 8'h33));
        emit(ia(3, 1, 8'h84));
        emit(BRK);
        runProg(16'h0060);
        `CHK({mem.dataMem[16'h0207], mem.dataMem[16'h0206]}, 16'h1333)
        `CHK({mem.dataMem[16'h0209], mem.dataMem[16'h0208]}, 16'h1333)
        rdChk(`BSP_STAT_OFS, 32'h3, 1'b0);
        for (int k = 0; k < 3; k++) begin
            progPtr = 16'h0070;
            emit(ib(k == 0 ? `BSP_OP_CMPI : `BSP_OP_ANDI, 1, imms[k]));
            emit(BRK);
            runProg(16'h0070);
            rdChk(`BSP_STAT_OFS, stats[k], 1'b0);
        end
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 2; v++) begin
                ext = v ? 4'ha : 4'h5;
                tk = c[2] ? ext[c[1:0]] : (c[0] == v[0]);
                extCond <= ext;
                clearMarks();
                progPtr = 16'h0040;
                emit(ia(6, 4, 8'h10));
                emit(ia(6, 5, 8'h77));
                emit(ib(`BSP_OP_CMPI, 4, v ? 8'h20 : 8'h10));
                emit(ib(`BSP_OP_BRANCH, c[2:0], 8'h04));
                emit(ia(4, 5, 8'h00));
                emit(ia(4, 5, 8'h01));
                emit(ia(4, 5, 8'h02));
                emit(BRK);
                runProg(16'h0040);
                `CHK(mem.dataMem[16'h0100], 8'h77)
                `CHK(mem.dataMem[16'h0101], tk ? 8'h00 : 8'h77)
                `CHK(mem.dataMem[16'h0102], 8'h77)
            end
        end
        extCond <= 4'h0;
        clearMarks();
        progPtr = 16'h0080;
        emit(ib(`BSP_OP_CMPI, 4, 8'h10));
        emit(ib(`BSP_OP_CALL, 0, 8'h1c));
        emit(ia(4, 5, 8'h00));
        emit(ia(4, 5, 8'h03));
        emit(BRK);
        progPtr = 16'h00a0;
        emit(ib(`BSP_OP_SUB_EXIT, 7, 8'h00));
        emit(ia(4, 5, 8'h01));
        emit(ia(4, 5, 8'h02));
        emit(BRK);
        runProg(16'h0080);
        `CHK({mem.dataMem[16'h0103], mem.dataMem[16'h0101], mem.dataMem[16'h0100]},
            24'h777777)
        `CHK(mem.dataMem[16'h0102], 8'h00)
        extCond <= 4'hf;
        clearMarks();
        progPtr = 16'h00b0;
        emit(ia(6, 6, 8'hd0));
        emit(ia(7, 6, 8'h00));
        emit(ib(`BSP_OP_JUMP_REG, 6, 8'h00));
        emit(ia(4, 5, 8'h00));
        emit(ia(4, 5, 8'h01));
        emit(BRK);
        progPtr = 16'h00d0;
        emit(ia(4, 5, 8'h02));
        emit(BRK);
        runProg(16'h00b0);
        `CHK(mem.dataMem[16'h0100], 8'h77)
        `CHK(mem.dataMem[16'h0101], 8'h00)
        `CHK(mem.dataMem[16'h0102], 8'h77)
        // A backward branch lands on the stop word one word past the register target.
        progPtr = 16'h00e0;
        emit(ib(`BSP_OP_BRANCH, 7, 8'hf0));
        emit(ia(4, 5, 8'h03));
        runProg(16'h00e0);
        rdChk(`BSP_PC_OFS, 32'hd4, 1'b0);
        `CHK(mem.dataMem[16'h0103], 8'h77)
        giveVerdict();
    end
endmodule
`default_nettype wire
